// *** hdl/crxbs_pkg.sv ***
package crxbs_pkg;

    localparam int          CRXBS_NFILT0       = 2;
    localparam int          CRXBS_NFILT1       = 4;
    localparam int          CRXBS_NFILT        = 6;

    localparam logic [7:0]  CRXBS_OFS_BFP      = 8'h0c;
    localparam logic [7:0]  CRXBS_OFS_B0_CTRL  = 8'h60;
    localparam logic [7:0]  CRXBS_OFS_B0_SIDH  = 8'h61;
    localparam logic [7:0]  CRXBS_OFS_B1_CTRL  = 8'h70;
    localparam logic [7:0]  CRXBS_OFS_B1_SIDH  = 8'h71;
    localparam logic [7:0]  CRXBS_OFS_INTE     = 8'h20;
    localparam logic [7:0]  CRXBS_OFS_INTF     = 8'h21;
    localparam logic [7:0]  CRXBS_OFS_ERROR_FLAG_REGISTER     = 8'h22;
    localparam logic [7:0]  CRXBS_OFS_STAT     = 8'h23;

    localparam int          CRXBS_BFP_MODE_LSB = 0;
    localparam int          CRXBS_BFP_EN_LSB   = 2;
    localparam int          CRXBS_BFP_LVL_LSB  = 4;
    localparam int          CRXBS_CTRL_POL_LSB = 5;
    localparam int          CRXBS_CTRL_RTR     = 3;
    localparam int          CRXBS_CTRL_ROLL    = 2;
    localparam int          CRXBS_CTRL_ROLLM   = 1;
    localparam int          CRXBS_CTRL_HIT_LSB = 0;
    localparam int          CRXBS_INTF_RX0     = 0;
    localparam int          CRXBS_INTF_RX1     = 1;
    localparam int          CRXBS_INTE_RX0     = 0;
    localparam int          CRXBS_INTE_RX1     = 1;
    localparam int          CRXBS_INTE_ERR     = 5;
    localparam int          CRXBS_ERROR_FLAG_REGISTER_OVR0    = 6;
    localparam int          CRXBS_ERROR_FLAG_REGISTER_OVR1    = 7;

    localparam logic [5:0]  CRXBS_BFP_RST      = 6'h00;
    localparam logic [7:0]  CRXBS_REG_RST      = 8'h00;
    localparam logic [2:0]  CRXBS_HIT_RST      = 3'h0;
    localparam logic [2:0]  CRXBS_HIT1_BASE    = 3'h2;

    localparam logic [3:0]  CRXBS_STAT_NONE    = 4'h0;
    localparam logic [3:0]  CRXBS_STAT_RECEIVE_SLOT_ZERO    = 4'h1;
    localparam logic [3:0]  CRXBS_STAT_RECEIVE_SLOT_ONE    = 4'h2;

    typedef enum logic [1:0]
    {
        CRXBS_POL_MATCH = 2'b00,
        CRXBS_POL_STD   = 2'b01,
        CRXBS_POL_EXT   = 2'b10,
        CRXBS_POL_ANY   = 2'b11
    } crxbs_policy_t;

    typedef struct packed
    {
        logic        valid;
        logic        ext;
        logic        rtr;
        logic [10:0] short_identifier;
        logic [5:0]  hit;
    } crxbs_frame_t;

    typedef struct packed
    {
        logic en;
        logic mode;
        logic level;
    } crxbs_pincfg_t;

endpackage

// *** hdl/crxbs_accept.sv ***
`timescale 1ns/1ns
module crxbs_accept
#(
    parameter int NFILT = 2,
    parameter int IW    = 1
)
(
    input  wire crxbs_pkg::crxbs_policy_t policy_i,
    input  wire logic                     valid_i,
    input  wire logic                     ext_i,
    input  wire logic [NFILT-1:0]         hit_i,
    output logic                          accept_o,
    output logic [IW-1:0]                 index_o
);

    logic match;

    always_comb
    begin
        // Lowest numbered matching filter wins when several match.
        index_o = '0;
        for (int i = NFILT - 1; i >= 0; i--)
        begin
            if (hit_i[i])
            begin
                index_o = IW'(i);
            end
        end
        match = |hit_i;
        unique case (policy_i)
            crxbs_pkg::CRXBS_POL_ANY:   accept_o = 1'b1;
            crxbs_pkg::CRXBS_POL_EXT:   accept_o = valid_i & ext_i & match;
            crxbs_pkg::CRXBS_POL_STD:   accept_o = valid_i & ~ext_i & match;
            crxbs_pkg::CRXBS_POL_MATCH: accept_o = valid_i & match;
        endcase
    end

endmodule // crxbs_accept

// *** hdl/crxbs_pin.sv ***
`timescale 1ns/1ns
module crxbs_pin
(
    input  wire logic                    clk_i,
    input  wire logic                    srst_i,
    input  wire crxbs_pkg::crxbs_pincfg_t cfg_i,
    input  wire logic                    flag_i,
    output logic                         pin_o,
    output logic                         pin_oe_n_o
);

    logic pin_r;
    logic pin_nxt;
    logic oe_n_r;
    logic oe_n_nxt;

    always_comb
    begin
        if (!cfg_i.en)
        begin
            oe_n_nxt = 1'b1;
            pin_nxt  = 1'b1;
        end
        else if (cfg_i.mode)
        begin
            oe_n_nxt = 1'b0;
            pin_nxt  = ~flag_i;
        end
        else
        begin
            oe_n_nxt = 1'b0;
            pin_nxt  = cfg_i.level;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pin_r  <= 1'b1;
            oe_n_r <= 1'b1;
        end
        else
        begin
            pin_r  <= pin_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    assign pin_o      = pin_r;
    assign pin_oe_n_o = oe_n_r;

endmodule // crxbs_pin

// *** hdl/crxbs_top.sv ***
`timescale 1ns/1ns
module crxbs_top
(
    input  wire logic                   CLK_I,
    input  wire logic                   SRST_I,
    input  wire logic                   REG_WR_I,
    input  wire logic                   REG_RD_I,
    input  wire logic [7:0]             REG_ADDR_I,
    input  wire logic [7:0]             REG_DATA_I,
    input  wire logic [7:0]             REG_MASK_I,
    output logic      [7:0]             REG_RDATA_O,
    input  wire logic                   FRM_DONE_I,
    input  wire crxbs_pkg::crxbs_frame_t FRM_I,
    output logic                        ERR_FRAME_O,
    output logic                        INT_N_O,
    output logic      [1:0]             FULL_PIN_O,
    output logic      [1:0]             FULL_PIN_OE_N_O
);

    logic [5:0]               bfp_r;
    logic [5:0]               bfp_nxt;
    crxbs_pkg::crxbs_policy_t pol0_r;
    crxbs_pkg::crxbs_policy_t pol0_nxt;
    crxbs_pkg::crxbs_policy_t pol1_r;
    crxbs_pkg::crxbs_policy_t pol1_nxt;
    logic                     roll_r;
    logic                     roll_nxt;
    logic                     rtr0_r;
    logic                     rtr0_nxt;
    logic                     rtr1_r;
    logic                     rtr1_nxt;
    logic                     hit0_r;
    logic                     hit0_nxt;
    logic [2:0]               hit1_r;
    logic [2:0]               hit1_nxt;
    logic [7:0]               sidh0_r;
    logic [7:0]               sidh0_nxt;
    logic [7:0]               sidh1_r;
    logic [7:0]               sidh1_nxt;
    logic [7:0]               inte_r;
    logic [7:0]               inte_nxt;
    logic                     flag0_r;
    logic                     flag0_nxt;
    logic                     flag1_r;
    logic                     flag1_nxt;
    logic                     ovr0_r;
    logic                     ovr0_nxt;
    logic                     ovr1_r;
    logic                     ovr1_nxt;
    logic [3:0]               stat_r;
    logic [3:0]               stat_nxt;
    logic [7:0]               rdata_r;
    logic [7:0]               rdata_nxt;
    logic                     errf_r;
    logic                     errf_nxt;
    logic                     int_n_r;
    logic                     int_n_nxt;

    logic                     acc0;
    logic                     acc1;
    logic [0:0]               idx0;
    logic [1:0]               idx1;
    logic                     load0;
    logic                     load1;
    logic                     roll_go;
    logic                     set_ovr0;
    logic                     set_ovr1;
    logic [7:0]               ctrl0_rd;
    logic [7:0]               ctrl1_rd;
    logic [7:0]               bfp_rd;
    logic [7:0]               intf_rd;
    logic [7:0]               error_flag_register_rd;
    logic [7:0]               bfp_mrg;
    logic [7:0]               ctrl0_mrg;
    logic [7:0]               ctrl1_mrg;
    logic [7:0]               intf_mrg;
    logic [7:0]               error_flag_register_mrg;
    logic [1:0]               flags;
    crxbs_pkg::crxbs_pincfg_t pin_cfg [2];

    // Masked write; a full write is a mask of all ones.
    function automatic logic [7:0] merge(input logic [7:0] old_v);
        merge = (old_v & ~REG_MASK_I) | (REG_DATA_I & REG_MASK_I);
    endfunction

    function automatic logic hit_wr(input logic [7:0] ofs);
        hit_wr = REG_WR_I && (REG_ADDR_I == ofs);
    endfunction

    // Merged write values are kept as nets so single fields can be picked.
    assign bfp_mrg   = merge({2'b00, bfp_r});
    assign ctrl0_mrg = merge(ctrl0_rd);
    assign ctrl1_mrg = merge(ctrl1_rd);
    assign intf_mrg  = merge(intf_rd);
    assign error_flag_register_mrg  = merge(error_flag_register_rd);

    crxbs_accept
    #(
        .NFILT (crxbs_pkg::CRXBS_NFILT0),
        .IW    (1)
    )
    u_accept0
    (
        .policy_i (pol0_r),
        .valid_i  (FRM_I.valid),
        .ext_i    (FRM_I.ext),
        .hit_i    (FRM_I.hit[crxbs_pkg::CRXBS_NFILT0-1:0]),
        .accept_o (acc0),
        .index_o  (idx0)
    );

    crxbs_accept
    #(
        .NFILT (crxbs_pkg::CRXBS_NFILT1),
        .IW    (2)
    )
    u_accept1
    (
        .policy_i (pol1_r),
        .valid_i  (FRM_I.valid),
        .ext_i    (FRM_I.ext),
        .hit_i    (FRM_I.hit[crxbs_pkg::CRXBS_NFILT-1:
                             crxbs_pkg::CRXBS_NFILT0]),
        .accept_o (acc1),
        .index_o  (idx1)
    );

    // Steering. Buffer zero is tried first; an invalid frame is only
    // taken by a buffer whose policy accepts anything, or by buffer one when buffer zero rolls it over.
    always_comb
    begin
        load0    = 1'b0;
        load1    = 1'b0;
        roll_go  = 1'b0;
        set_ovr0 = 1'b0;
        set_ovr1 = 1'b0;
        if (FRM_DONE_I)
        begin
            if (acc0)
            begin
                if (!flag0_r)
                begin
                    load0 = 1'b1;
                end
                else if (roll_r)
                begin
                    roll_go = 1'b1;
                    if (!flag1_r)
                    begin
                        load1 = 1'b1;
                    end
                    else
                    begin
                        set_ovr1 = 1'b1;
                    end
                end
                else
                begin
                    set_ovr0 = 1'b1;
                end
            end
            else if (acc1)
            begin
                if (!flag1_r)
                begin
                    load1 = 1'b1;
                end
                else
                begin
                    set_ovr1 = 1'b1;
                end
            end
            // Anything else is simply dropped.
        end
    end

    always_comb
    begin
        bfp_nxt   = bfp_r;
        pol0_nxt  = pol0_r;
        pol1_nxt  = pol1_r;
        roll_nxt  = roll_r;
        inte_nxt  = inte_r;
        rtr0_nxt  = rtr0_r;
        rtr1_nxt  = rtr1_r;
        hit0_nxt  = hit0_r;
        hit1_nxt  = hit1_r;
        sidh0_nxt = sidh0_r;
        sidh1_nxt = sidh1_r;
        stat_nxt  = stat_r;
        flag0_nxt = flag0_r;
        flag1_nxt = flag1_r;
        ovr0_nxt  = ovr0_r;
        ovr1_nxt  = ovr1_r;
        if (hit_wr(crxbs_pkg::CRXBS_OFS_BFP))
        begin
            bfp_nxt = bfp_mrg[5:0];
        end
        if (hit_wr(crxbs_pkg::CRXBS_OFS_B0_CTRL))
        begin
            pol0_nxt = crxbs_pkg::crxbs_policy_t'(
                ctrl0_mrg[crxbs_pkg::CRXBS_CTRL_POL_LSB +: 2]);
            roll_nxt = ctrl0_mrg[crxbs_pkg::CRXBS_CTRL_ROLL];
        end
        if (hit_wr(crxbs_pkg::CRXBS_OFS_B1_CTRL))
        begin
            pol1_nxt = crxbs_pkg::crxbs_policy_t'(
                ctrl1_mrg[crxbs_pkg::CRXBS_CTRL_POL_LSB +: 2]);
        end
        if (hit_wr(crxbs_pkg::CRXBS_OFS_INTE))
        begin
            inte_nxt = merge(inte_r);
        end
        // Software can only clear flags; a set in the same cycle wins.
        if (hit_wr(crxbs_pkg::CRXBS_OFS_INTF))
        begin
            flag0_nxt = flag0_r & intf_mrg[crxbs_pkg::CRXBS_INTF_RX0];
            flag1_nxt = flag1_r & intf_mrg[crxbs_pkg::CRXBS_INTF_RX1];
        end
        if (hit_wr(crxbs_pkg::CRXBS_OFS_ERROR_FLAG_REGISTER))
        begin
            ovr0_nxt = ovr0_r & error_flag_register_mrg[crxbs_pkg::CRXBS_ERROR_FLAG_REGISTER_OVR0];
            ovr1_nxt = ovr1_r & error_flag_register_mrg[crxbs_pkg::CRXBS_ERROR_FLAG_REGISTER_OVR1];
        end
        if (load0)
        begin
            flag0_nxt = 1'b1;
            hit0_nxt  = idx0;
            rtr0_nxt  = FRM_I.rtr;
            sidh0_nxt = FRM_I.short_identifier[10:3];
            stat_nxt  = crxbs_pkg::CRXBS_STAT_RECEIVE_SLOT_ZERO;
        end
        if (load1)
        begin
            flag1_nxt = 1'b1;
            rtr1_nxt  = FRM_I.rtr;
            sidh1_nxt = FRM_I.short_identifier[10:3];
            stat_nxt  = crxbs_pkg::CRXBS_STAT_RECEIVE_SLOT_ONE;
            if (roll_go)
            begin
                hit1_nxt = {2'b00, idx0};
            end
            else
            begin
                hit1_nxt = crxbs_pkg::CRXBS_HIT1_BASE + {1'b0, idx1};
            end
        end
        if (set_ovr0)
        begin
            ovr0_nxt = 1'b1;
        end
        if (set_ovr1)
        begin
            ovr1_nxt = 1'b1;
        end
    end

    // Interrupt-mode pins read their level bit as zero.
    assign bfp_rd   = {2'b00,
                       bfp_r[crxbs_pkg::CRXBS_BFP_LVL_LSB +: 2] &
                       ~bfp_r[crxbs_pkg::CRXBS_BFP_MODE_LSB +: 2],
                       bfp_r[3:0]};
    assign ctrl0_rd = {1'b0, pol0_r, 1'b0, rtr0_r, roll_r,
                       roll_r, hit0_r};
    assign ctrl1_rd = {1'b0, pol1_r, 1'b0, rtr1_r, hit1_r};
    assign intf_rd  = {6'h00, flag1_r, flag0_r};
    assign error_flag_register_rd  = {ovr1_r, ovr0_r, 6'h00};

    always_comb
    begin
        rdata_nxt = rdata_r;
        if (REG_RD_I)
        begin
            unique case (REG_ADDR_I)
                crxbs_pkg::CRXBS_OFS_BFP:     rdata_nxt = bfp_rd;
                crxbs_pkg::CRXBS_OFS_B0_CTRL: rdata_nxt = ctrl0_rd;
                crxbs_pkg::CRXBS_OFS_B0_SIDH: rdata_nxt = sidh0_r;
                crxbs_pkg::CRXBS_OFS_B1_CTRL: rdata_nxt = ctrl1_rd;
                crxbs_pkg::CRXBS_OFS_B1_SIDH: rdata_nxt = sidh1_r;
                crxbs_pkg::CRXBS_OFS_INTE:    rdata_nxt = inte_r;
                crxbs_pkg::CRXBS_OFS_INTF:    rdata_nxt = intf_rd;
                crxbs_pkg::CRXBS_OFS_ERROR_FLAG_REGISTER:    rdata_nxt = error_flag_register_rd;
                crxbs_pkg::CRXBS_OFS_STAT:    rdata_nxt = {4'h0, stat_r};
                default:                      rdata_nxt = 8'h00;
            endcase
        end
        errf_nxt  = FRM_DONE_I & ~FRM_I.valid;
        // The level follows the next-state flags, so a load shows on the
        // interrupt output in the same edge as its flag.
        int_n_nxt = ~((flag0_nxt & inte_nxt[crxbs_pkg::CRXBS_INTE_RX0]) |
                      (flag1_nxt & inte_nxt[crxbs_pkg::CRXBS_INTE_RX1]) |
                      ((ovr0_nxt | ovr1_nxt) &
                       inte_nxt[crxbs_pkg::CRXBS_INTE_ERR]));
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            bfp_r   <= crxbs_pkg::CRXBS_BFP_RST;
            pol0_r  <= crxbs_pkg::CRXBS_POL_MATCH;
            pol1_r  <= crxbs_pkg::CRXBS_POL_MATCH;
            roll_r  <= 1'b0;
            rtr0_r  <= 1'b0;
            rtr1_r  <= 1'b0;
            hit0_r  <= 1'b0;
            hit1_r  <= crxbs_pkg::CRXBS_HIT_RST;
            sidh0_r <= crxbs_pkg::CRXBS_REG_RST;
            sidh1_r <= crxbs_pkg::CRXBS_REG_RST;
            inte_r  <= crxbs_pkg::CRXBS_REG_RST;
            flag0_r <= 1'b0;
            flag1_r <= 1'b0;
            ovr0_r  <= 1'b0;
            ovr1_r  <= 1'b0;
            stat_r  <= crxbs_pkg::CRXBS_STAT_NONE;
            rdata_r <= crxbs_pkg::CRXBS_REG_RST;
            errf_r  <= 1'b0;
            int_n_r <= 1'b1;
        end
        else
        begin
            bfp_r   <= bfp_nxt;
            pol0_r  <= pol0_nxt;
            pol1_r  <= pol1_nxt;
            roll_r  <= roll_nxt;
            rtr0_r  <= rtr0_nxt;
            rtr1_r  <= rtr1_nxt;
            hit0_r  <= hit0_nxt;
            hit1_r  <= hit1_nxt;
            sidh0_r <= sidh0_nxt;
            sidh1_r <= sidh1_nxt;
            inte_r  <= inte_nxt;
            flag0_r <= flag0_nxt;
            flag1_r <= flag1_nxt;
            ovr0_r  <= ovr0_nxt;
            ovr1_r  <= ovr1_nxt;
            stat_r  <= stat_nxt;
            rdata_r <= rdata_nxt;
            errf_r  <= errf_nxt;
            int_n_r <= int_n_nxt;
        end
    end

    assign flags = {flag1_r, flag0_r};

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_pin
            assign pin_cfg[g] = '{en:    bfp_r[crxbs_pkg::CRXBS_BFP_EN_LSB + g],
                                  mode:  bfp_r[crxbs_pkg::CRXBS_BFP_MODE_LSB + g],
                                  level: bfp_r[crxbs_pkg::CRXBS_BFP_LVL_LSB + g]};

            crxbs_pin u_pin
            (
                .clk_i      (CLK_I),
                .srst_i     (SRST_I),
                .cfg_i      (pin_cfg[g]),
                .flag_i     (flags[g]),
                .pin_o      (FULL_PIN_O[g]),
                .pin_oe_n_o (FULL_PIN_OE_N_O[g])
            );
        end
    endgenerate

    assign REG_RDATA_O = rdata_r;
    assign ERR_FRAME_O = errf_r;
    assign INT_N_O     = int_n_r;

endmodule // crxbs_top

// *** verif/crxbs_monitor.sv ***
`timescale 1ns/1ns
module crxbs_monitor
(
    input  wire logic                    CLK_I,
    input  wire logic                    SRST_I,
    input  wire logic                    REG_WR_I,
    input  wire logic                    REG_RD_I,
    input  wire logic [7:0]              REG_ADDR_I,
    input  wire logic [7:0]              REG_DATA_I,
    input  wire logic [7:0]              REG_MASK_I,
    input  wire logic [7:0]              REG_RDATA_O,
    input  wire logic                    FRM_DONE_I,
    input  wire crxbs_pkg::crxbs_frame_t FRM_I,
    input  wire logic                    ERR_FRAME_O,
    input  wire logic [1:0]              FULL_PIN_O,
    input  wire logic [1:0]              FULL_PIN_OE_N_O
);
    // The pins lag the control register by one clock, so cfg_r is what
    // the pins should show now.
    logic [5:0] bfp_r;
    logic [5:0] bfp_nxt;
    logic [5:0] cfg_r;
    logic [5:0] cfg_nxt;

    always_comb
    begin
        bfp_nxt = bfp_r;
        cfg_nxt = bfp_r;
        if (REG_WR_I && REG_ADDR_I == 8'h0c)
            bfp_nxt = (bfp_r & ~REG_MASK_I[5:0])
                    | (REG_DATA_I[5:0] & REG_MASK_I[5:0]);
        if (SRST_I)
        begin
            bfp_nxt = 6'h00;
            cfg_nxt = 6'h00;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        bfp_r <= bfp_nxt;
        cfg_r <= cfg_nxt;
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    pin_float_a: assert property (
        (FULL_PIN_OE_N_O | cfg_r[3:2]) == 2'b11)
        else $error("disabled pin is driven");
    pin_zero_out_a: assert property (
        cfg_r[2] && !cfg_r[0] |-> !FULL_PIN_OE_N_O[0]
        && FULL_PIN_O[0] == cfg_r[4])
        else $error("pin zero output level wrong");
    pin_one_out_a: assert property (
        cfg_r[3] && !cfg_r[1] |-> !FULL_PIN_OE_N_O[1]
        && FULL_PIN_O[1] == cfg_r[5])
        else $error("pin one output level wrong");
    bfp_read_a: assert property (
        REG_RD_I && REG_ADDR_I == 8'h0c |=> REG_RDATA_O ==
        {2'b00, cfg_r[5:4] & ~cfg_r[1:0], cfg_r[3:0]})
        else $error("pin control read back wrong");
    err_frame_a: assert property (
        FRM_DONE_I && !FRM_I.valid |=> ERR_FRAME_O)
        else $error("no error frame for bad frame");
    err_cause_a: assert property (
        ERR_FRAME_O |-> $past(FRM_DONE_I) && !$past(FRM_I.valid))
        else $error("error frame without bad frame");
    mirror_read_a: assert property (
        REG_RD_I && REG_ADDR_I == 8'h60 |=>
        REG_RDATA_O[1] == REG_RDATA_O[2])
        else $error("rollover mirror differs");
    rdata_hold_a: assert property (
        !REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("read data moved without a read");
endmodule // crxbs_monitor

bind crxbs_top crxbs_monitor crxbs_monitor_i
(
    .CLK_I(CLK_I),
    .SRST_I(SRST_I),
    .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I),
    .REG_ADDR_I(REG_ADDR_I),
    .REG_DATA_I(REG_DATA_I),
    .REG_MASK_I(REG_MASK_I),
    .REG_RDATA_O(REG_RDATA_O),
    .FRM_DONE_I(FRM_DONE_I),
    .FRM_I(FRM_I),
    .ERR_FRAME_O(ERR_FRAME_O),
    .FULL_PIN_O(FULL_PIN_O),
    .FULL_PIN_OE_N_O(FULL_PIN_OE_N_O)
);

// *** verif/crxbs_host.sv ***
`timescale 1ns/1ns
module crxbs_host
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      data_o,
    output logic [7:0]      mask_o
);
    initial
    begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        data_o = 8'h00;
        mask_o = 8'h00;
    end

    // Released lines show the inverse so stale values never look valid.
    task automatic xfer(input logic w, input logic [7:0] a, d, m,
                        output logic [7:0] q);
        @(posedge clk_i);
        #1;
        wr_o = w;
        rd_o = !w;
        addr_o = a;
        data_o = d;
        mask_o = m;
        @(posedge clk_i);
        #1;
        q = rdata_i;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a;
        data_o = ~d;
        mask_o = ~m;
    endtask

    task automatic wr(input logic [7:0] a, d, m);
        logic [7:0] q;
        xfer(1'b1, a, d, m, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h00, 8'h00, q);
    endtask

    task automatic clr(input logic [7:0] m);
        wr(8'h21, 8'h00, m);
    endtask
endmodule // crxbs_host

// *** verif/crxbs_tb.sv ***
`timescale 1ns/1ns
module crxbs_tb;
    logic                    clk = 1'b0;
    logic                    srst = 1'b1;
    logic                    fdone = 1'b0;
    crxbs_pkg::crxbs_frame_t frm = '0;
    logic                    wr, rd, errf, int_n;
    logic [7:0]              addr, data, mask, rdata;
    logic [1:0]              pin, oe_n;
    int                      fail_count = 0;
    int                      compares = 0;
    logic [7:0]              alist [10] = '{8'h0c, 8'h20, 8'h21,
        8'h22, 8'h23, 8'h60, 8'h61, 8'h70, 8'h71, 8'h55};

    always #4 clk = ~clk;

    crxbs_host crxbs_host_i (.clk_i(clk), .rdata_i(rdata), .wr_o(wr),
        .rd_o(rd), .addr_o(addr), .data_o(data), .mask_o(mask));
    crxbs_top crxbs_top_i (.CLK_I(clk), .SRST_I(srst), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_DATA_I(data),
        .REG_MASK_I(mask), .REG_RDATA_O(rdata), .FRM_DONE_I(fdone),
        .FRM_I(frm), .ERR_FRAME_O(errf), .INT_N_O(int_n),
        .FULL_PIN_O(pin), .FULL_PIN_OE_N_O(oe_n));

    task automatic chk(input logic [7:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic crd(input logic [7:0] a, exp);
        logic [7:0] v;
        crxbs_host_i.rd(a, v);
        chk(v, exp);
    endtask

    task automatic frame(input logic v, e, r, input logic [10:0] s,
                         input logic [5:0] h);
        @(posedge clk);
        #1;
        fdone = 1'b1;
        frm = {v, e, r, s, h};
        @(posedge clk);
        #1;
        fdone = 1'b0;
        frm = ~frm;
    endtask

    task automatic settle_pins(input logic [7:0] exp);
        @(posedge clk);
        #1;
        chk({4'h0, pin, oe_n}, exp);
    endtask

    task automatic give_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        fail_count++;
        give_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        srst = 1'b0;
        foreach (alist[i]) crd(alist[i], 8'h00);
        chk({5'h0, int_n, oe_n}, 8'h07);
        crxbs_host_i.wr(8'h0c, 8'h3c, 8'hff);
        settle_pins(8'h0c);
        crxbs_host_i.wr(8'h0c, 8'h00, 8'h10);
        settle_pins(8'h08);
        crxbs_host_i.wr(8'h0c, 8'h03, 8'h03);
        crd(8'h0c, 8'h0f);
        chk({4'h0, pin, oe_n}, 8'h0c);
        crxbs_host_i.wr(8'h0c, 8'h00, 8'h0c);
        settle_pins(8'h0f);
        crxbs_host_i.wr(8'h0c, 8'h0c, 8'h0c);
        $display("test pins done");
        crxbs_host_i.wr(8'h20, 8'h23, 8'hff);
        frame(1'b1, 1'b0, 1'b1, 11'h5a3, 6'h02);
        chk({7'h0, int_n}, 8'h00);
        settle_pins(8'h08);
        crd(8'h21, 8'h01);
        crd(8'h60, 8'h09);
        crd(8'h61, 8'hb4);
        crd(8'h23, 8'h01);
        frame(1'b1, 1'b0, 1'b0, 11'h000, 6'h01);
        crd(8'h22, 8'h40);
        crd(8'h60, 8'h09);
        crxbs_host_i.wr(8'h60, 8'h04, 8'h04);
        crd(8'h60, 8'h0f);
        frame(1'b1, 1'b0, 1'b0, 11'h123, 6'h02);
        crd(8'h70, 8'h01);
        crd(8'h71, 8'h24);
        crd(8'h23, 8'h02);
        frame(1'b1, 1'b0, 1'b0, 11'h000, 6'h01);
        crd(8'h22, 8'hc0);
        crxbs_host_i.clr(8'h03);
        crxbs_host_i.wr(8'h22, 8'h00, 8'hc0);
        crd(8'h21, 8'h00);
        chk({4'h0, pin, oe_n}, 8'h0c);
        crxbs_host_i.wr(8'h70, 8'h40, 8'h60);
        frame(1'b1, 1'b0, 1'b0, 11'h7ff, 6'h10);
        crd(8'h21, 8'h00);
        frame(1'b1, 1'b1, 1'b0, 11'h7ff, 6'h10);
        crd(8'h70, 8'h44);
        crxbs_host_i.clr(8'h03);
        $display("test steering done");
        crxbs_host_i.wr(8'h60, 8'h00, 8'h04);
        crxbs_host_i.wr(8'h70, 8'h00, 8'h60);
        for (int p = 0; p < 4; p++)
            for (int e = 0; e < 2; e++)
                for (int h = 0; h < 2; h++)
                begin
                    crxbs_host_i.wr(8'h60, {1'b0, p[1:0], 5'h0}, 8'h60);
                    frame(1'b1, e[0], 1'b0, 11'h000, {5'h0, h[0]});
                    crd(8'h21, {7'h0, p == 3 || h == 1 && (p == 0 ||
                        p == 1 && e == 0 || p == 2 && e == 1)});
                    crxbs_host_i.clr(8'h03);
                end
        crd(8'h60, 8'h60);
        crxbs_host_i.wr(8'h60, 8'h00, 8'h60);
        frame(1'b0, 1'b0, 1'b0, 11'h000, 6'h01);
        chk({7'h0, errf}, 8'h01);
        crd(8'h21, 8'h00);
        crxbs_host_i.wr(8'h60, 8'h60, 8'h60);
        frame(1'b0, 1'b0, 1'b0, 11'h000, 6'h01);
        crd(8'h21, 8'h01);
        crxbs_host_i.clr(8'h03);
        crxbs_host_i.wr(8'h20, 8'h02, 8'hff);
        frame(1'b1, 1'b0, 1'b0, 11'h000, 6'h01);
        frame(1'b1, 1'b0, 1'b0, 11'h000, 6'h01);
        chk({7'h0, int_n}, 8'h01);
        $display("test policy done");
        give_verdict();
    end
endmodule // crxbs_tb
